// [design/frci_defs.svh]
// Constants of the frame rate capability register bank.
//
// Notes on behaviour
// - Bits 0 to 7 of a word stand in order for 1.875, 3.75, 7.5, 15, 30, 60, 120, 240 fps.
// - Word 0x234 (1024x768 mono 8-bit) has rate bits 0 to 7; bits 8 to 31 are reserved.
// - Word 0x238 (800x600 mono 16-bit) has rate bits 1 to 7; bits 0 and 8 to 31 are reserved.
// - Word 0x23C (1024x768 mono 16-bit) has rate bits 0 to 7; bits 8 to 31 are reserved.
// - Word 0x240 (1280x960 YUV 4:2:2) has rate bits 0 to 5 only; bits 6 to 31 are reserved.
// - Word 0x244 (1280x960 RGB 24-bit) has rate bits 0 to 5 only; bits 6 to 31 are reserved.
// - Word 0x248 (1280x960 mono 8-bit) has rate bits 0 to 6; bits 7 to 31 are reserved.
`ifndef FRCI_DEFS_SVH
`define FRCI_DEFS_SVH

`define FRCI_ADDR_W 12
`define FRCI_CNT_W 16

// Rate bit positions.
`define FRCI_BIT_FPS_1P875 0
`define FRCI_BIT_FPS_3P75 1
`define FRCI_BIT_FPS_7P5 2
`define FRCI_BIT_FPS_15 3
`define FRCI_BIT_FPS_30 4
`define FRCI_BIT_FPS_60 5
`define FRCI_BIT_FPS_120 6
`define FRCI_BIT_FPS_240 7

// Register offsets (byte addresses).
`define FRCI_OFF_CTRL 12'h000
`define FRCI_OFF_STAT 12'h004
`define FRCI_OFF_XGA_MONO8 12'h234
`define FRCI_OFF_SVGA_MONO16 12'h238
`define FRCI_OFF_XGA_MONO16 12'h23C
`define FRCI_OFF_SXGA_YUV422 12'h240
`define FRCI_OFF_SXGA_RGB24 12'h244
`define FRCI_OFF_SXGA_MONO8 12'h248

// Control field and reset values.
`define FRCI_CTRL_ERR_EN_BIT 0
`define FRCI_CTRL_RST 1'b1
`define FRCI_CNT_RST 16'h0000

// AXI response codes.
`define FRCI_RESP_OKAY 2'h0
`define FRCI_RESP_SLVERR 2'h2

`endif

// [design/frci_pkg.sv]
// Types shared by the frame rate capability register bank.
package frci_pkg;
  typedef logic [31:0] frci_word_t;
  typedef logic [1:0] frci_resp_t;
  // Which kind of register an address selects.
  typedef enum {FRCI_HIT_CAP, FRCI_HIT_CTRL, FRCI_HIT_STAT, FRCI_HIT_NONE} frci_hit_t;
endpackage

// [design/frci_regs.sv]
// AXI4-Lite slave holding the frame rate capability words.
`timescale 1ns/1ps
`include "frci_defs.svh"

module frci_regs #(
  parameter int ADDR_W = `FRCI_ADDR_W, // Address bus width.
  parameter int CNT_W = `FRCI_CNT_W // Width of the refused write counter.
) (
  input wire logic aclk, // System clock, 40 MHz.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire frci_pkg::frci_word_t s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output frci_pkg::frci_resp_t s_axi_bresp, // Write response code.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output frci_pkg::frci_word_t s_axi_rdata, // Read data.
  output frci_pkg::frci_resp_t s_axi_rresp, // Read response code.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready // Read data ready.
);
  import frci_pkg::*;

  // Rate masks, one bit per standard frame rate.
  localparam frci_word_t M1P875 = 32'h00000001 << `FRCI_BIT_FPS_1P875;
  localparam frci_word_t M3P75 = 32'h00000001 << `FRCI_BIT_FPS_3P75;
  localparam frci_word_t M7P5 = 32'h00000001 << `FRCI_BIT_FPS_7P5;
  localparam frci_word_t M15 = 32'h00000001 << `FRCI_BIT_FPS_15;
  localparam frci_word_t M30 = 32'h00000001 << `FRCI_BIT_FPS_30;
  localparam frci_word_t M60 = 32'h00000001 << `FRCI_BIT_FPS_60;
  localparam frci_word_t M120 = 32'h00000001 << `FRCI_BIT_FPS_120;
  localparam frci_word_t M240 = 32'h00000001 << `FRCI_BIT_FPS_240;
  localparam frci_word_t UP_TO_60 = M1P875 | M3P75 | M7P5 | M15 | M30 | M60;

  // Fixed capability words; every reserved bit is left at zero.
  localparam frci_word_t CAP_XGA_MONO8 = UP_TO_60 | M120 | M240;
  localparam frci_word_t CAP_SVGA_MONO16 = (UP_TO_60 & ~M1P875) | M120 | M240;
  localparam frci_word_t CAP_XGA_MONO16 = UP_TO_60 | M120 | M240;
  localparam frci_word_t CAP_SXGA_YUV422 = UP_TO_60;
  localparam frci_word_t CAP_SXGA_RGB24 = UP_TO_60;
  localparam frci_word_t CAP_SXGA_MONO8 = UP_TO_60 | M120;

  // Classify a byte address; the two low bits are ignored.
  function automatic frci_hit_t hit_of(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    w = {a[ADDR_W-1:2], 2'b00};
    if (w == ADDR_W'(`FRCI_OFF_CTRL)) begin
      hit_of = FRCI_HIT_CTRL;
    end else if (w == ADDR_W'(`FRCI_OFF_STAT)) begin
      hit_of = FRCI_HIT_STAT;
    end else if (w >= ADDR_W'(`FRCI_OFF_XGA_MONO8) && w <= ADDR_W'(`FRCI_OFF_SXGA_MONO8)) begin
      hit_of = FRCI_HIT_CAP;
    end else begin
      hit_of = FRCI_HIT_NONE;
    end
  endfunction

  // Capability value for an address; zero outside the capability words.
  function automatic frci_word_t cap_of(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    w = {a[ADDR_W-1:2], 2'b00};
    if (w == ADDR_W'(`FRCI_OFF_XGA_MONO8)) begin
      cap_of = CAP_XGA_MONO8;
    end else if (w == ADDR_W'(`FRCI_OFF_SVGA_MONO16)) begin
      cap_of = CAP_SVGA_MONO16;
    end else if (w == ADDR_W'(`FRCI_OFF_XGA_MONO16)) begin
      cap_of = CAP_XGA_MONO16;
    end else if (w == ADDR_W'(`FRCI_OFF_SXGA_YUV422)) begin
      cap_of = CAP_SXGA_YUV422;
    end else if (w == ADDR_W'(`FRCI_OFF_SXGA_RGB24)) begin
      cap_of = CAP_SXGA_RGB24;
    end else if (w == ADDR_W'(`FRCI_OFF_SXGA_MONO8)) begin
      cap_of = CAP_SXGA_MONO8;
    end else begin
      cap_of = 32'h00000000;
    end
  endfunction

  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic aw_got_r, aw_got_nxt;
  logic w_got_r, w_got_nxt;
  logic [ADDR_W-1:0] waddr_r, waddr_nxt;
  frci_word_t wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt;
  frci_resp_t bresp_r, bresp_nxt;
  logic err_en_r, err_en_nxt;
  logic [CNT_W-1:0] refused_r, refused_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  frci_word_t rdata_r, rdata_nxt;
  frci_resp_t rresp_r, rresp_nxt;
  logic aw_hs, w_hs, ar_hs, do_write;
  frci_hit_t whit, rhit;

  // Handshakes and the decoded targets of the held write and the offered read.
  assign aw_hs = s_axi_awvalid && awready_r;
  assign w_hs = s_axi_wvalid && wready_r;
  assign ar_hs = s_axi_arvalid && arready_r;
  assign do_write = aw_got_r && w_got_r && !bvalid_r;
  assign whit = hit_of(waddr_r);
  assign rhit = hit_of(s_axi_araddr);

  // Write path: address and data are caught in either order, the write
  // happens once both are held, and the response is raised a cycle later.
  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    waddr_nxt = waddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    err_en_nxt = err_en_r;
    refused_nxt = refused_r;
    if (aw_hs) begin
      aw_got_nxt = 1'b1;
      waddr_nxt = s_axi_awaddr;
    end
    if (w_hs) begin
      w_got_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (do_write) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = `FRCI_RESP_OKAY;
      if (whit == FRCI_HIT_CTRL) begin
        if (wstrb_r[0]) begin
          err_en_nxt = wdata_r[`FRCI_CTRL_ERR_EN_BIT];
        end
      end else if (whit == FRCI_HIT_CAP) begin
        // Capability words are constants; the write is only counted.
        if (refused_r != {CNT_W{1'b1}}) begin
          refused_nxt = refused_r + CNT_W'(1);
        end
      end else if (whit == FRCI_HIT_NONE) begin
        bresp_nxt = err_en_r ? `FRCI_RESP_SLVERR : `FRCI_RESP_OKAY;
      end
    end
    // Ready stays low while a half is held or a response waits, so a
    // second write cannot overrun the first.
    awready_nxt = !aw_got_nxt && !bvalid_nxt;
    wready_nxt = !w_got_nxt && !bvalid_nxt;
  end

  // Write path registers; reset leaves every ready low for one cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      waddr_r <= '0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `FRCI_RESP_OKAY;
      err_en_r <= `FRCI_CTRL_RST;
      refused_r <= `FRCI_CNT_RST;
    end else begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      waddr_r <= waddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      err_en_r <= err_en_nxt;
      refused_r <= refused_nxt;
    end
  end

  // Read path: one read at a time, answered on the edge after the address.
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (ar_hs) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = `FRCI_RESP_OKAY;
      if (rhit == FRCI_HIT_CTRL) begin
        rdata_nxt = 32'h00000000;
        rdata_nxt[`FRCI_CTRL_ERR_EN_BIT] = err_en_r;
      end else if (rhit == FRCI_HIT_STAT) begin
        rdata_nxt = 32'(refused_r);
      end else if (rhit == FRCI_HIT_CAP) begin
        rdata_nxt = cap_of(s_axi_araddr);
      end else begin
        rdata_nxt = 32'h00000000;
        rresp_nxt = err_en_r ? `FRCI_RESP_SLVERR : `FRCI_RESP_OKAY;
      end
    end
    arready_nxt = !rvalid_nxt;
  end

  // Read path registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `FRCI_RESP_OKAY;
    end else begin
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // All outputs come straight from flip-flops.
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // Checks on the read answers, the write handshake and what writes change.
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_rd(logic [ADDR_W-1:0] a);
    ar_hs && {s_axi_araddr[ADDR_W-1:2], 2'b00} == a;
  endsequence

  sequence s_answer(frci_word_t v);
    rvalid_r && rdata_r == v && rresp_r == `FRCI_RESP_OKAY;
  endsequence

  chk_rate_bit_order: assert property (s_rd(ADDR_W'(`FRCI_OFF_XGA_MONO8)) |=>
    rdata_r[7:0] == 8'hFF && rdata_r[31:8] == 24'h000000)
    else $error("Rate bits of the 1024x768 mono 8-bit word are wrong.");
  chk_cap_xga_mono8: assert property (s_rd(ADDR_W'(`FRCI_OFF_XGA_MONO8)) |=>
    s_answer(32'h000000FF))
    else $error("Word at 0x234 read wrong.");
  chk_cap_svga_mono16: assert property (s_rd(ADDR_W'(`FRCI_OFF_SVGA_MONO16)) |=>
    s_answer(32'h000000FE))
    else $error("Word at 0x238 read wrong.");
  chk_cap_xga_mono16: assert property (s_rd(ADDR_W'(`FRCI_OFF_XGA_MONO16)) |=>
    s_answer(32'h000000FF))
    else $error("Word at 0x23C read wrong.");
  chk_cap_sxga_yuv: assert property (s_rd(ADDR_W'(`FRCI_OFF_SXGA_YUV422)) |=>
    s_answer(32'h0000003F))
    else $error("Word at 0x240 read wrong.");
  chk_cap_sxga_rgb: assert property (s_rd(ADDR_W'(`FRCI_OFF_SXGA_RGB24)) |=>
    s_answer(32'h0000003F))
    else $error("Word at 0x244 read wrong.");
  chk_cap_sxga_mono8: assert property (s_rd(ADDR_W'(`FRCI_OFF_SXGA_MONO8)) |=>
    s_answer(32'h0000007F))
    else $error("Word at 0x248 read wrong.");
  chk_cap_write_ignored: assert property (do_write && whit == FRCI_HIT_CAP &&
    refused_r != {CNT_W{1'b1}} |=> bvalid_r && bresp_r == `FRCI_RESP_OKAY &&
    refused_r == $past(refused_r) + CNT_W'(1) && err_en_r == $past(err_en_r))
    else $error("Write to a capability word was not ignored and counted.");
  chk_read_held: assert property (rvalid_r && !s_axi_rready |=>
    rvalid_r && $stable(rdata_r) && $stable(rresp_r) && !arready_r)
    else $error("Read answer changed before it was taken.");
  chk_write_answer: assert property (aw_hs && w_hs |-> ##2 bvalid_r)
    else $error("Write response not raised two cycles after the request.");
  // A stuck ready or a stray reserved bit would otherwise only show as a hung master.
  chk_read_answer: assert property (ar_hs |=> rvalid_r && !arready_r)
    else $error("Read answer not raised one cycle after the address.");
  chk_cap_reserved: assert property (ar_hs && rhit == FRCI_HIT_CAP |=>
    rdata_r[31:8] == 24'h000000)
    else $error("Reserved bits of a capability word read as one.");
  chk_resp_held: assert property (bvalid_r && !s_axi_bready |=>
    bvalid_r && $stable(bresp_r) && !awready_r && !wready_r)
    else $error("Write response changed before it was taken.");
  chk_ctrl_write: assert property (do_write && whit == FRCI_HIT_CTRL && wstrb_r[0] |=>
    err_en_r == $past(wdata_r[`FRCI_CTRL_ERR_EN_BIT]))
    else $error("Control write did not reach the error enable.");
  chk_unmapped_err: assert property (ar_hs && rhit == FRCI_HIT_NONE && err_en_r |=>
    rdata_r == 32'h00000000 && rresp_r == `FRCI_RESP_SLVERR)
    else $error("Unmapped read did not answer with an error.");
  chk_unmapped_write: assert property (do_write && whit == FRCI_HIT_NONE && err_en_r |=>
    bvalid_r && bresp_r == `FRCI_RESP_SLVERR)
    else $error("Unmapped write did not answer with an error.");
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the frame rate capability register bank.
`timescale 1ns/1ps
`include "frci_defs.svh"

module tb_top;
  import frci_pkg::*;
  localparam int WAIT_MAX = 200;
  logic aclk;
  logic aresetn;
  logic [11:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  frci_word_t s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  frci_resp_t s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [11:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  frci_word_t s_axi_rdata;
  frci_resp_t s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  int mismatches = 0;
  int cmp_count = 0;

  frci_regs i_frci_regs (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

  // Clock at 40 MHz.
  initial aclk = 1'b0;
  always #12.5 aclk = ~aclk;

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // A handshake that never comes is a mismatch and ends the run at once.
  task automatic give_up(input string what);
    $display("CHECK FAILED %s expected answer seen none", what);
    mismatches++;
    close_out();
  endtask

  task automatic cmp_word(input string what, input frci_word_t exp, input frci_word_t got);
    cmp_count++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask

  task automatic cmp_resp(input string what, input frci_resp_t exp, input frci_resp_t got);
    cmp_count++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      mismatches++;
    end
  endtask

  // Write cycle: address and data offered together, each released when taken.
  task automatic axi_write(input logic [11:0] a, input frci_word_t d, output frci_resp_t r);
    bit aw_ok;
    bit w_ok;
    int n;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok) && n < WAIT_MAX) begin
      @(posedge aclk);
      n++;
      if (s_axi_awready && !aw_ok) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !w_ok) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_bvalid && n < WAIT_MAX);
    if (n >= WAIT_MAX) give_up("write response");
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // Read cycle: rready stays high until the data is sampled.
  task automatic axi_read(input logic [11:0] a, output frci_word_t d, output frci_resp_t r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_arready && n < WAIT_MAX);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_rvalid && n < WAIT_MAX);
    if (n >= WAIT_MAX) give_up("read data");
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Offered rates per word, as first and last rate bit; everything else reads zero.
  logic [11:0] cap_addr [6] = '{`FRCI_OFF_XGA_MONO8, `FRCI_OFF_SVGA_MONO16,
    `FRCI_OFF_XGA_MONO16, `FRCI_OFF_SXGA_YUV422, `FRCI_OFF_SXGA_RGB24, `FRCI_OFF_SXGA_MONO8};
  int cap_lo [6] = '{0, 1, 0, 0, 0, 0};
  int cap_hi [6] = '{7, 7, 7, 5, 5, 6};

  function automatic frci_word_t rate_mask(input int lo, input int hi);
    frci_word_t m;
    m = 32'h0000_0000;
    for (int b = lo; b <= hi; b++) m[b] = 1'b1;
    return m;
  endfunction

  // Every capability word, read back to back, twice over.
  task automatic scn_caps_read();
    frci_word_t d;
    frci_resp_t r;
    int j;
    for (int k = 0; k < 12; k++) begin
      j = k % 6;
      axi_read(cap_addr[j], d, r);
      cmp_word("cap word", rate_mask(cap_lo[j], cap_hi[j]), d);
      cmp_resp("cap rresp", `FRCI_RESP_OKAY, r);
    end
  endtask

  // All-ones writes must leave reserved and unoffered bits untouched.
  task automatic scn_caps_write();
    frci_word_t d;
    frci_resp_t r;
    for (int k = 0; k < 6; k++) begin
      axi_write(cap_addr[k], 32'hFFFF_FFFF, r);
      cmp_resp("cap bresp", `FRCI_RESP_OKAY, r);
      axi_read(cap_addr[k], d, r);
      cmp_word("cap after write", rate_mask(cap_lo[k], cap_hi[k]), d);
    end
    axi_read(`FRCI_OFF_STAT, d, r);
    cmp_word("write count", 32'h0000_0006, d);
  endtask

  // Answers left waiting three cycles must stand and hold off the next request.
  task automatic scn_stall();
    int n;
    bit aw_ok;
    bit w_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= `FRCI_OFF_SVGA_MONO16;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_arready && n < WAIT_MAX);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_rvalid && n < WAIT_MAX);
    if (n >= WAIT_MAX) give_up("stalled read");
    repeat (3) begin
      @(posedge aclk);
      cmp_word("held rdata", rate_mask(1, 7), s_axi_rdata);
      cmp_bit("held rvalid", 1'b1, s_axi_rvalid);
      cmp_bit("arready while held", 1'b0, s_axi_arready);
    end
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    cmp_word("stalled rdata", rate_mask(1, 7), s_axi_rdata);
    s_axi_rready <= 1'b0;
    s_axi_awaddr <= `FRCI_OFF_XGA_MONO16;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= 32'h0000_0000;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok) && n < WAIT_MAX) begin
      @(posedge aclk);
      n++;
      if (s_axi_awready && !aw_ok) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !w_ok) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_bvalid && n < WAIT_MAX);
    if (n >= WAIT_MAX) give_up("stalled write");
    repeat (3) begin
      @(posedge aclk);
      cmp_resp("held bresp", `FRCI_RESP_OKAY, s_axi_bresp);
      cmp_bit("held bvalid", 1'b1, s_axi_bvalid);
      cmp_bit("awready while held", 1'b0, s_axi_awready);
    end
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    cmp_bit("bvalid at take", 1'b1, s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  // Words just outside the bank are not capability words.
  task automatic scn_unmapped();
    frci_word_t d;
    frci_resp_t r;
    axi_read(12'h230, d, r);
    cmp_word("below bank", 32'h0000_0000, d);
    cmp_resp("below rresp", `FRCI_RESP_SLVERR, r);
    axi_read(12'h24C, d, r);
    cmp_resp("above rresp", `FRCI_RESP_SLVERR, r);
    cmp_word("above bank", 32'h0000_0000, d);
    axi_read(`FRCI_OFF_CTRL, d, r);
    cmp_word("ctrl at reset", 32'h0000_0001, d);
    axi_write(12'h24C, 32'h0000_0000, r);
    cmp_resp("above bresp", `FRCI_RESP_SLVERR, r);
    axi_write(`FRCI_OFF_CTRL, 32'h0000_0000, r);
    cmp_resp("ctrl bresp", `FRCI_RESP_OKAY, r);
    axi_read(`FRCI_OFF_CTRL, d, r);
    cmp_word("ctrl cleared", 32'h0000_0000, d);
    axi_read(12'h24C, d, r);
    cmp_resp("quiet rresp", `FRCI_RESP_OKAY, r);
    axi_read(`FRCI_OFF_SXGA_MONO8, d, r);
    cmp_word("last cap", rate_mask(0, 6), d);
  endtask

  // Main sequence; inputs are given values at time zero, reset held for 16 cycles.
  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = 12'h000;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 12'h000;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    scn_caps_read();
    scn_caps_write();
    scn_stall();
    scn_unmapped();
    close_out();
  end
endmodule
